// >>> rtl/alc_pkg.sv
// alc_pkg: constants for the averaged limit checker
// assumes a 40 MHz system clock and an apb register port
package alc_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SLOW_PERIOD_MS = 1280;
  localparam int unsigned FAST_PERIOD_MS = 320;
  localparam int unsigned DELAY_STEP_MS = 100;
  localparam int unsigned SLOW_PERIOD_CYC = CLK_HZ / 1000 * SLOW_PERIOD_MS;
  localparam int unsigned FAST_PERIOD_CYC = CLK_HZ / 1000 * FAST_PERIOD_MS;
  localparam int unsigned DELAY_STEP_CYC = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam logic [3:0] DELAY_MAX_STEPS = 4'ha;
  localparam logic [6:0] PCT_MAX = 7'h64;
  localparam logic [6:0] DEPTH_SLOW = 7'h40;
  localparam logic [6:0] DEPTH_NORMAL = 7'h10;
  localparam logic [6:0] DEPTH_FAST = 7'h04;

  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_HIGH = 8'h04;
  localparam logic [7:0] OFF_LOW = 8'h08;
  localparam logic [7:0] OFF_CENTRE = 8'h0c;
  localparam logic [7:0] OFF_PCT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_AVG = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h1c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;

  // ctrl fields
  localparam int CTRL_AVG_LSB = 0;
  localparam int CTRL_ENTRY_BIT = 2;
  localparam int CTRL_TEST_EN_BIT = 3;
  localparam int CTRL_DELAY_LSB = 4;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_MASK = 32'h0000_00ff;

  // irq bits
  localparam int IRQ_RESULT_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_AVG_BIT = 2;

  typedef enum logic [1:0] {
    ALC_AVG_SLOW = 2'h0,
    ALC_AVG_NORMAL = 2'h1,
    ALC_AVG_FAST = 2'h2
  } alc_avg_t;

  typedef enum logic [1:0] {
    ALC_MODE_CONST_CURR = 2'h0,
    ALC_MODE_CONST_RES = 2'h1,
    ALC_MODE_CONST_VOLT = 2'h2,
    ALC_MODE_CONST_PWR = 2'h3
  } alc_load_mode_t;

  typedef enum logic [2:0] {
    ALC_ST_IDLE = 3'b001,
    ALC_ST_DELAY = 3'b010,
    ALC_ST_CHECK = 3'b100
  } alc_state_t;
endpackage : alc_pkg

// >>> rtl/alc_checker.sv
// alc_checker: sample averaging and pass/fail limit checking
// assumes samples arrive as one-cycle strobes with 16-bit unsigned data
`timescale 1ns/1ps
`default_nettype none
module alc_checker
  import alc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sample_valid_i,
  input wire logic [15:0] volt_sample_i,
  input wire logic [15:0] curr_sample_i,
  input wire logic load_on_i,
  input wire logic [1:0] load_mode_i,
  input wire logic save_i,
  input wire logic recall_i,
  output logic [15:0] display_o,
  output logic display_stb_o,
  output logic armed_o,
  output logic pass_o,
  output logic fail_indication_o,
  output logic alarm_o,
  output logic irq_o
);

  function automatic logic [6:0] avg_depth(input logic [1:0] sel);
    unique case (sel)
      ALC_AVG_NORMAL: avg_depth = DEPTH_NORMAL;
      ALC_AVG_FAST: avg_depth = DEPTH_FAST;
      default: avg_depth = DEPTH_SLOW;
    endcase
  endfunction : avg_depth

  function automatic logic [16:0] pct_of(input logic [15:0] c, input logic [6:0] p);
    logic [22:0] prod;
    prod = c * p;
    pct_of = 17'(prod / 23'd100);
  endfunction : pct_of

  logic apb_wr, apb_rd;
  assign apb_wr = psel_i & penable_i & pwrite_i;
  assign apb_rd = psel_i & penable_i & ~pwrite_i;
  assign pready_o = 1'b1;

  // ---------------- registers ----------------
  logic [7:0] ctrl_q, ctrl_d, sv_ctrl_q, sv_ctrl_d;
  logic [15:0] high_q, high_d, low_q, low_d, cent_q, cent_d;
  logic [15:0] sv_high_q, sv_high_d, sv_low_q, sv_low_d, sv_cent_q, sv_cent_d;
  logic [13:0] pct_q, pct_d, sv_pct_q, sv_pct_d;
  logic [2:0] istat_q, istat_d, imask_q, imask_d;
  logic [2:0] ev;
  logic bad_addr;

  always_comb
  begin
    ctrl_d = ctrl_q;
    high_d = high_q;
    low_d = low_q;
    cent_d = cent_q;
    pct_d = pct_q;
    imask_d = imask_q;
    sv_ctrl_d = sv_ctrl_q;
    sv_high_d = sv_high_q;
    sv_low_d = sv_low_q;
    sv_cent_d = sv_cent_q;
    sv_pct_d = sv_pct_q;
    if (apb_wr)
    begin
      unique case (paddr_i)
        OFF_CTRL: ctrl_d = pwdata_i[7:0];
        OFF_HIGH: high_d = pwdata_i[15:0];
        OFF_LOW: low_d = pwdata_i[15:0];
        OFF_CENTRE: cent_d = pwdata_i[15:0];
        OFF_PCT: pct_d = {pwdata_i[14:8], pwdata_i[6:0]};
        OFF_IRQ_MASK: imask_d = pwdata_i[2:0];
        default: ;
      endcase
    end
    if (save_i)
    begin
      sv_ctrl_d = ctrl_q;
      sv_high_d = high_q;
      sv_low_d = low_q;
      sv_cent_d = cent_q;
      sv_pct_d = pct_q;
    end
    else if (recall_i)
    begin
      ctrl_d = sv_ctrl_q;
      high_d = sv_high_q;
      low_d = sv_low_q;
      cent_d = sv_cent_q;
      pct_d = sv_pct_q;
    end
    // out-of-range settings are clamped (avg select 3 falls back to slow) rather than refused
    if (ctrl_d[1:0] == 2'h3)
    begin
      ctrl_d[1:0] = 2'h0;
    end
    if (ctrl_d[7:4] > DELAY_MAX_STEPS)
    begin
      ctrl_d[7:4] = DELAY_MAX_STEPS;
    end
    if (pct_d[6:0] > PCT_MAX)
    begin
      pct_d[6:0] = PCT_MAX;
    end
    if (pct_d[13:7] > PCT_MAX)
    begin
      pct_d[13:7] = PCT_MAX;
    end
    // set wins over write-one-to-clear
    istat_d = (istat_q & ~((apb_wr && paddr_i == OFF_IRQ_STAT) ? pwdata_i[2:0] : 3'h0)) | ev;
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctrl_q <= CTRL_RESET[7:0];
      high_q <= 16'h0000;
      low_q <= 16'h0000;
      cent_q <= 16'h0000;
      pct_q <= 14'h0000;
      istat_q <= 3'h0;
      imask_q <= 3'h0;
      sv_ctrl_q <= CTRL_RESET[7:0];
      sv_high_q <= 16'h0000;
      sv_low_q <= 16'h0000;
      sv_cent_q <= 16'h0000;
      sv_pct_q <= 14'h0000;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      high_q <= high_d;
      low_q <= low_d;
      cent_q <= cent_d;
      pct_q <= pct_d;
      istat_q <= istat_d;
      imask_q <= imask_d;
      sv_ctrl_q <= sv_ctrl_d;
      sv_high_q <= sv_high_d;
      sv_low_q <= sv_low_d;
      sv_cent_q <= sv_cent_d;
      sv_pct_q <= sv_pct_d;
    end
  end

  // ---------------- averaging ----------------
  logic [21:0] acc_q, acc_d;
  logic [6:0] cnt_q, cnt_d;
  logic [15:0] avg_q, avg_d;
  logic avg_new_q, avg_new_d;
  logic [25:0] per_q, per_d;
  logic [15:0] disp_q, disp_d;
  logic disp_stb_q, disp_stb_d;
  logic [15:0] sel_sample;
  logic [6:0] depth;
  logic [25:0] per_len;

  assign sel_sample = (load_mode_i == ALC_MODE_CONST_VOLT) ? curr_sample_i : volt_sample_i;
  assign depth = avg_depth(ctrl_q[1:0]);
  assign per_len = (ctrl_q[1:0] == ALC_AVG_NORMAL || ctrl_q[1:0] == ALC_AVG_FAST) ?
                   26'(FAST_PERIOD_CYC) : 26'(SLOW_PERIOD_CYC);

  always_comb
  begin
    acc_d = acc_q;
    cnt_d = cnt_q;
    avg_d = avg_q;
    avg_new_d = 1'b0;
    per_d = per_q + 26'h1;
    disp_d = disp_q;
    disp_stb_d = 1'b0;
    if (sample_valid_i)
    begin
      if (cnt_q + 7'h1 >= depth)
      begin
        unique case (depth)
          DEPTH_FAST: avg_d = 16'((acc_q + 22'(sel_sample)) >> 2);
          DEPTH_NORMAL: avg_d = 16'((acc_q + 22'(sel_sample)) >> 4);
          default: avg_d = 16'((acc_q + 22'(sel_sample)) >> 6);
        endcase
        avg_new_d = 1'b1;
        acc_d = 22'h0;
        cnt_d = 7'h0;
      end
      else
      begin
        acc_d = acc_q + 22'(sel_sample);
        cnt_d = cnt_q + 7'h1;
      end
    end
    if (per_q + 26'h1 >= per_len)
    begin
      per_d = 26'h0;
      disp_d = avg_q;
      disp_stb_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      acc_q <= 22'h0;
      cnt_q <= 7'h0;
      avg_q <= 16'h0;
      avg_new_q <= 1'b0;
      per_q <= 26'h0;
      disp_q <= 16'h0;
      disp_stb_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      avg_q <= avg_d;
      avg_new_q <= avg_new_d;
      per_q <= per_d;
      disp_q <= disp_d;
      disp_stb_q <= disp_stb_d;
    end
  end

  // ---------------- limit check ----------------
  alc_state_t st_q, st_d;
  logic [22:0] dly_q, dly_d;
  logic [3:0] step_q, step_d;
  logic res_valid_q, res_valid_d, pass_q, pass_d;
  logic [16:0] hi_lim, lo_lim, dev_hi, dev_lo;
  logic in_lim;

  assign dev_hi = pct_of(cent_q, pct_q[13:7]);
  assign dev_lo = pct_of(cent_q, pct_q[6:0]);
  assign hi_lim = ctrl_q[CTRL_ENTRY_BIT] ? 17'(cent_q) + dev_hi : 17'(high_q);
  assign lo_lim = ctrl_q[CTRL_ENTRY_BIT] ? 17'(cent_q) - dev_lo : 17'(low_q);
  assign in_lim = (17'(avg_q) <= hi_lim) && (17'(avg_q) >= lo_lim);

  always_comb
  begin
    st_d = st_q;
    dly_d = dly_q;
    step_d = step_q;
    res_valid_d = res_valid_q;
    pass_d = pass_q;
    ev = 3'h0;
    // disarm or load off restarts the delay
    if (!ctrl_q[CTRL_TEST_EN_BIT] || !load_on_i)
    begin
      st_d = ALC_ST_IDLE;
      res_valid_d = 1'b0;
      pass_d = 1'b0;
    end
    else
    begin
      unique case (st_q)
        ALC_ST_IDLE:
        begin
          st_d = ALC_ST_DELAY;
          dly_d = 23'h0;
          step_d = 4'h0;
        end
        ALC_ST_DELAY:
        begin
          if (step_q >= ctrl_q[7:4])
          begin
            st_d = ALC_ST_CHECK;
          end
          else if (dly_q + 23'h1 >= 23'(DELAY_STEP_CYC))
          begin
            dly_d = 23'h0;
            step_d = step_q + 4'h1;
          end
          else
          begin
            dly_d = dly_q + 23'h1;
          end
        end
        ALC_ST_CHECK:
        begin
          if (avg_new_q)
          begin
            res_valid_d = 1'b1;
            pass_d = in_lim;
            ev[IRQ_RESULT_BIT] = 1'b1;
            ev[IRQ_FAIL_BIT] = ~in_lim;
          end
        end
        default: st_d = ALC_ST_IDLE;
      endcase
    end
    if (disp_stb_q)
    begin
      ev[IRQ_AVG_BIT] = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st_q <= ALC_ST_IDLE;
      dly_q <= 23'h0;
      step_q <= 4'h0;
      res_valid_q <= 1'b0;
      pass_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      dly_q <= dly_d;
      step_q <= step_d;
      res_valid_q <= res_valid_d;
      pass_q <= pass_d;
    end
  end

  // ---------------- outputs ----------------
  assign display_o = disp_q;
  assign display_stb_o = disp_stb_q;
  assign armed_o = ctrl_q[CTRL_TEST_EN_BIT];
  assign pass_o = res_valid_q & pass_q;
  assign fail_indication_o = res_valid_q & ~pass_q;
  assign alarm_o = res_valid_q & ~pass_q;
  assign irq_o = |(istat_q & imask_q);

  always_comb
  begin
    bad_addr = 1'b0;
    prdata_o = 32'h0;
    if (apb_rd)
    begin
      unique case (paddr_i)
        OFF_CTRL: prdata_o = {24'h0, ctrl_q};
        OFF_HIGH: prdata_o = {16'h0, high_q};
        OFF_LOW: prdata_o = {16'h0, low_q};
        OFF_CENTRE: prdata_o = {16'h0, cent_q};
        OFF_PCT: prdata_o = {17'h0, pct_q[13:7], 1'b0, pct_q[6:0]};
        OFF_STATUS: prdata_o = {26'h0, st_q, fail_indication_o, pass_o, armed_o};
        OFF_AVG: prdata_o = {16'h0, disp_q};
        OFF_IRQ_STAT: prdata_o = {29'h0, istat_q};
        OFF_IRQ_MASK: prdata_o = {29'h0, imask_q};
        default: bad_addr = 1'b1;
      endcase
    end
    else if (apb_wr)
    begin
      bad_addr = !(paddr_i == OFF_CTRL || paddr_i == OFF_HIGH || paddr_i == OFF_LOW ||
                   paddr_i == OFF_CENTRE || paddr_i == OFF_PCT || paddr_i == OFF_IRQ_STAT ||
                   paddr_i == OFF_IRQ_MASK);
    end
  end
  assign pslverr_o = bad_addr;

  // ---------------- assertions ----------------
  sequence s_load_up;
    load_on_i && armed_o;
  endsequence

  a_no_early_result: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    $rose(load_on_i) |-> !res_valid_q [*2]) else $error("result before delay");
  a_alarm_eq_fail: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    alarm_o == fail_indication_o) else $error("alarm differs from fail");
  a_armed_ctrl: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !armed_o |=> !pass_o && !fail_indication_o) else $error("result while disarmed");
  a_fast_depth: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ctrl_q[1:0] == ALC_AVG_FAST && sample_valid_i && cnt_q == 7'h3) |=> avg_new_q)
    else $error("fast average not 4");
  a_normal_depth: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ctrl_q[1:0] == ALC_AVG_NORMAL && sample_valid_i && cnt_q < 7'hf) |=> !avg_new_q)
    else $error("normal average early");
  a_slow_depth: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (ctrl_q[1:0] == ALC_AVG_SLOW && sample_valid_i && cnt_q == 7'h3f) |=> avg_new_q)
    else $error("slow average not 64");
  a_off_clears: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    !load_on_i |=> st_q == ALC_ST_IDLE && !res_valid_q) else $error("delay not restarted");
  a_pass_limits: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    (s_load_up and (st_q == ALC_ST_CHECK && avg_new_q)) |=> pass_o == $past(in_lim))
    else $error("pass does not follow limits");
  a_volt_mode_current: assert property (@(posedge mclk_i) disable iff (!rstn_i)
    load_mode_i == ALC_MODE_CONST_VOLT |-> sel_sample == curr_sample_i) else $error("voltage mode not current");
endmodule : alc_checker
`default_nettype wire

// >>> testbench/alc_meas_model.sv
// alc_meas_model: measurement path handing samples to the checker
// assumes one strobe per sample, driven just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module alc_meas_model (
  input wire logic mclk_i,
  output logic sample_valid_o,
  output logic [15:0] volt_o,
  output logic [15:0] curr_o
);
  initial
  begin
    sample_valid_o = 1'b0;
    volt_o = 16'h0;
    curr_o = 16'h0;
  end

  task automatic send(input logic [15:0] v, input logic [15:0] c, input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      sample_valid_o <= 1'b1;
      volt_o <= v;
      curr_o <= c;
      @(posedge mclk_i);
      sample_valid_o <= 1'b0;
      // data are not held once the strobe drops
      volt_o <= ~v;
      curr_o <= ~c;
    end
  endtask : send
endmodule : alc_meas_model
`default_nettype wire

// >>> testbench/alc_checker_test.sv
// alc_checker_test: apb register tests and limit scenarios
// assumes alc_meas_model beside the checker and a 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module alc_checker_test;
  import alc_pkg::*;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic perr;
  logic perr_q = 1'b0;
  logic [31:0] rdat;
  logic sv;
  logic [15:0] volt;
  logic [15:0] curr;
  logic load_on = 1'b0;
  logic [1:0] lmode = 2'h0;
  logic save = 1'b0;
  logic recall = 1'b0;
  logic armed;
  logic pass;
  logic fail;
  logic alarm;
  logic irq;
  int bad_count = 0;
  int compares = 0;
  logic [15:0] pv [4] = '{16'h044c, 16'h044d, 16'h0320, 16'h031f};

  always #12.5 mclk_i = ~mclk_i;

  alc_meas_model u_alc_meas_model (.mclk_i(mclk_i), .sample_valid_o(sv), .volt_o(volt), .curr_o(curr));

  alc_checker u_alc_checker (.mclk_i(mclk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(perr), .sample_valid_i(sv), .volt_sample_i(volt), .curr_sample_i(curr),
    .load_on_i(load_on), .load_mode_i(lmode), .save_i(save), .recall_i(recall), .display_o(),
    .display_stb_o(), .armed_o(armed), .pass_o(pass), .fail_indication_o(fail), .alarm_o(alarm),
    .irq_o(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    pen <= 1'b1;
    @(posedge mclk_i);
    while (pready !== 1'b1 && n < 100)
    begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 100)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, pready, 1'b1);
    end
    rdat = prdata;
    perr_q = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk_i);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask : rd

  task automatic res(input logic [15:0] v, input logic [15:0] c, input int n, input logic [2:0] e);
    u_alc_meas_model.send(v, c, n);
    repeat (3) @(posedge mclk_i);
    chk({29'h0, alarm, fail, pass}, {29'h0, e});
  endtask : res

  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    #(25 * 30000);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    repeat (20) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    rd(OFF_CTRL, CTRL_RESET);
    rd(8'h40, 32'h0);
    chk({31'h0, perr_q}, 32'h1);
    apb(1'b1, OFF_HIGH, 32'h3e8);
    apb(1'b1, OFF_LOW, 32'h1f4);
    apb(1'b1, OFF_CTRL, 32'h0a);
    chk({31'h0, armed}, 32'h1);
    res(16'h07d0, 16'h0, 4, 3'b000);
    load_on <= 1'b1;
    res(16'h03e8, 16'h0, 4, 3'b001);
    res(16'h03e9, 16'h0, 4, 3'b110);
    for (int m = 0; m < 4; m++)
    begin
      lmode <= 2'(m);
      res(16'h02bc, 16'h07d0, 4, (m == 2) ? 3'b110 : 3'b001);
    end
    lmode <= 2'h0;
    // depth 64, 16, 4: only the fast average sees the 1600 tail alone
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, OFF_CTRL, 32'h08 | 32'(i));
      repeat (2)
      begin
        u_alc_meas_model.send(16'h0258, 16'h0, (64 >> (2 * i)) - 4);
        u_alc_meas_model.send(16'h0640, 16'h0, 4);
      end
      res(16'h0640, 16'h0, 0, (i == 2) ? 3'b110 : 3'b001);
    end
    apb(1'b1, OFF_CENTRE, 32'h3e8);
    apb(1'b1, OFF_PCT, 32'h0a14);
    apb(1'b1, OFF_CTRL, 32'h0e);
    for (int k = 0; k < 4; k++)
      res(pv[k], 16'h0, 4, k[0] ? 3'b110 : 3'b001);
    apb(1'b1, OFF_IRQ_MASK, 32'h2);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_IRQ_STAT, 32'h7);
    chk({31'h0, irq}, 32'h0);
    res(16'h07d0, 16'h0, 4, 3'b110);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, OFF_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    save <= 1'b1;
    @(posedge mclk_i);
    save <= 1'b0;
    apb(1'b1, OFF_HIGH, 32'h1234);
    recall <= 1'b1;
    @(posedge mclk_i);
    recall <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rd(OFF_HIGH, 32'h3e8);
    load_on <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk({29'h0, alarm, fail, pass}, 32'h0);
    print_verdict();
  end
endmodule : alc_checker_test
`default_nettype wire
